// file: hw/toe_pkg.sv
// Purpose: shared constants and types of the transfer overflow/eject block
// Assumes: APB register map, 32-bit words
// Notes:   all offsets are byte addresses
package toe_pkg;
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_CFG       = 8'h04;
    localparam logic [7:0]  OFF_RLEN      = 8'h08;
    localparam logic [7:0]  OFF_HYST      = 8'h0c;
    localparam logic [7:0]  OFF_TMO       = 8'h10;
    localparam logic [7:0]  OFF_STAT      = 8'h14;
    localparam int          CTRL_START    = 0;
    localparam int          CTRL_STOP     = 1;
    localparam int          CTRL_FLUSH    = 2;
    localparam int          CFG_CONT      = 0;
    localparam int          CFG_HDR       = 1;
    localparam int          CFG_PART      = 2;
    localparam int          CFG_SRC_LO    = 4;
    localparam int          STAT_RUN      = 0;
    localparam int          STAT_OVF      = 1;
    localparam int          STAT_BLK      = 2;
    localparam int          STAT_LVL_LO   = 16;
    localparam int          HDR_LOST_BIT  = 0;
    localparam int          HDR_LEN_LO    = 8;
    localparam logic [31:0] UNBOUNDED_LEN = 32'hffff_ffff;
    localparam logic [31:0] RLEN_RST      = 32'h0000_0100;
    localparam logic [7:0]  HYST_RST      = 8'h04;
    localparam logic [7:0]  HYST_MAX      = 8'h64;
    localparam logic [7:0]  HYST_STEP_MSK = 8'hfe;
    localparam logic [31:0] TMO_RST       = 32'h0000_0000;

    typedef enum logic [1:0] {SRC_NONE, SRC_REC_END, SRC_PATTERN} toe_src_e;
    typedef enum logic {RD_DATA, RD_HDR} toe_rd_e;

    typedef struct packed {
        logic        cont;
        logic        hdr;
        logic        part;
        toe_src_e    src;
    } toe_cfg_s;

    typedef struct packed {
        logic        last;
        logic        lost;
        logic        nodata;
        logic [31:0] data;
    } toe_entry_s;
endpackage

// file: hw/toe_core.sv
// Purpose: on-board staging memory, overflow handling and buffer eject
// Assumes: acquisition words arrive without back-pressure
// Notes:   APB slave with no wait state on any access
`timescale 1ns/1ps
// Notes on behaviour
// - Halt acquisition on overflow unless continuing
// - Any dropped word counts as overflow
// - Stalled link: hold data, drop only when full
// - Stored data survives overflow and drains normally
// - No free host buffer: suspend, keep data
// - Continue mode truncates hit records, keeps running
// - Mark data-lost bit in record header
// - Refuse continue mode with unbounded length
// - Block writes until refill margin drained
// - Margin is rounded; readback shows applied value
// - Eject hands partial buffer over at once
// - Eject with empty buffer is ignored
// - Software flush honoured unless buffer empty
// - Idle timeout ejects; zero disables it
// - Each record restarts the idle count
// - Record-end source ejects after each record
// - Pattern source ejects while its input high
// - Header word follows each record when enabled
// - Incomplete record signals discard unless partial
module toe_core
    import toe_pkg::*;
#(
    parameter int DEPTH    = 1024,
    parameter int TB_WORDS = 64,
    parameter int CREDITS  = 4
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // Acquisition stream
    input  wire logic        acq_valid,
    input  wire logic [31:0] acq_data,
    input  wire logic        acq_last,
    input  wire logic        pat_gen_in,
    // Host link
    output logic             link_valid,
    output logic [31:0]      link_data,
    input  wire logic        link_ready,
    output logic             tb_handover,
    output logic [31:0]      tb_words,
    input  wire logic        buf_release,
    output logic             discard_evt
);
    localparam int AW = $clog2(DEPTH);
    localparam int FW = $clog2(TB_WORDS + 1);

    function automatic logic addr_ok(input logic [7:0] a);
        return a inside {OFF_CTRL, OFF_CFG, OFF_RLEN, OFF_HYST, OFF_TMO, OFF_STAT};
    endfunction

    toe_entry_s     mem [DEPTH];
    logic [AW-1:0]  wr_ptr_q, rd_ptr_q;
    logic [AW:0]    level_q;
    toe_cfg_s       cfg_q;
    logic [31:0]    rlen_q, tmo_q, rec_cnt_q, idle_q, prdata_q;
    logic [7:0]     hyst_q, hyst_d;
    logic           run_q, ovf_q, block_q, drop_q, term_pend_q, rec_lost_q;
    logic [7:0]     credits_q;
    logic [FW-1:0]  fill_q;
    logic           lv_q, ll_q, ej_pend_q, disc_q, hand_q;
    logic [31:0]    ld_q, words_q, hdr_q;
    toe_rd_e        rd_st_q;
    logic [23:0]    rd_len_q;

    // APB decode
    logic acc, wr, start_p, stop_p, flush_p;
    assign acc     = psel & penable;
    assign wr      = acc & pwrite & addr_ok(paddr);
    assign start_p = wr & (paddr == OFF_CTRL) & pwdata[CTRL_START];
    assign stop_p  = wr & (paddr == OFF_CTRL) & pwdata[CTRL_STOP];
    assign flush_p = wr & (paddr == OFF_CTRL) & pwdata[CTRL_FLUSH];
    assign pready  = acc;
    assign pslverr = acc & ~addr_ok(paddr);
    assign prdata  = prdata_q;

    // Continue mode only takes effect with a bounded length
    logic cont_eff;
    assign cont_eff = cfg_q.cont & (rlen_q != UNBOUNDED_LEN);

    // Requested margin is clamped and rounded to even percent
    always_comb begin
        hyst_d = (pwdata[7:0] > HYST_MAX) ? HYST_MAX : pwdata[7:0];
        hyst_d = hyst_d & HYST_STEP_MSK;
    end

    logic [31:0] margin, thresh;
    assign margin = (32'(DEPTH) * 32'(hyst_q)) / 32'd100;
    assign thresh = 32'(DEPTH) - margin;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q  <= '{cont: 1'b0, hdr: 1'b0, part: 1'b0, src: SRC_NONE};
            rlen_q <= RLEN_RST;
            hyst_q <= HYST_RST;
            tmo_q  <= TMO_RST;
        end else if (wr) begin
            unique case (paddr)
                OFF_CFG: begin
                    cfg_q.cont <= pwdata[CFG_CONT];
                    cfg_q.hdr  <= pwdata[CFG_HDR];
                    cfg_q.part <= pwdata[CFG_PART];
                    cfg_q.src  <= toe_src_e'(pwdata[CFG_SRC_LO +: 2]);
                end
                OFF_RLEN: rlen_q <= pwdata;
                OFF_HYST: hyst_q <= hyst_d;
                OFF_TMO:  tmo_q  <= pwdata;
                default: ;
            endcase
        end
    end

    // Read data is captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (psel & ~penable) begin
            prdata_q <= 32'h0;
            unique case (paddr)
                OFF_CFG: begin
                    prdata_q[CFG_CONT]         <= cont_eff;
                    prdata_q[CFG_HDR]          <= cfg_q.hdr;
                    prdata_q[CFG_PART]         <= cfg_q.part;
                    prdata_q[CFG_SRC_LO +: 2]  <= cfg_q.src;
                end
                OFF_RLEN: prdata_q <= rlen_q;
                OFF_HYST: prdata_q[7:0] <= hyst_q;
                OFF_TMO:  prdata_q <= tmo_q;
                OFF_STAT: begin
                    prdata_q[STAT_RUN]               <= run_q;
                    prdata_q[STAT_OVF]               <= ovf_q;
                    prdata_q[STAT_BLK]               <= block_q;
                    prdata_q[STAT_LVL_LO +: AW + 1]  <= level_q;
                end
                default: ;
            endcase
        end
    end

    // Write side
    logic full, empty, acc_w, rec_end, can_wr, lose, ovf_ev, dat_wr, term_wr, pop;
    assign full    = level_q == (AW + 1)'(DEPTH);
    assign empty   = level_q == '0;
    assign acc_w   = acq_valid & run_q;
    assign rec_end = acq_last | ((rlen_q != UNBOUNDED_LEN) & (rec_cnt_q + 32'd1 == rlen_q));
    assign can_wr  = ~full & ~block_q & ~drop_q & ~term_pend_q;
    assign dat_wr  = acc_w & can_wr;
    assign lose    = acc_w & ~can_wr;
    assign ovf_ev  = acc_w & (full | block_q);
    assign term_wr = term_pend_q & ~full;

    toe_entry_s wr_ent;
    always_comb begin
        if (term_wr) begin
            wr_ent = '{last: 1'b1, lost: 1'b1, nodata: 1'b1, data: 32'h0};
        end else begin
            wr_ent = '{last: rec_end, lost: rec_lost_q, nodata: 1'b0, data: acq_data};
        end
    end

    // Existing entries are never touched by an overflow
    always_ff @(posedge pclk) begin
        if (dat_wr | term_wr) begin
            mem[wr_ptr_q] <= wr_ent;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            level_q  <= '0;
        end else begin
            if (dat_wr | term_wr) begin
                wr_ptr_q <= wr_ptr_q + AW'(1);
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + AW'(1);
            end
            level_q <= level_q + (AW + 1)'(dat_wr | term_wr) - (AW + 1)'(pop);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
        end else if (start_p) begin
            run_q <= 1'b1;
        end else if (stop_p | (ovf_ev & ~cont_eff)) begin
            run_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_q <= 1'b0;
        end else if (ovf_ev) begin
            ovf_q <= 1'b1;
        end else if (start_p) begin
            ovf_q <= 1'b0;
        end
    end

    // Hysteresis: refill stays blocked until margin drained
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_q <= 1'b0;
        end else if (ovf_ev & cont_eff) begin
            block_q <= 1'b1;
        end else if (start_p | (32'(level_q) <= thresh)) begin
            block_q <= 1'b0;
        end
    end

    // Truncation of records hit by an overflow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drop_q      <= 1'b0;
            term_pend_q <= 1'b0;
            rec_lost_q  <= 1'b0;
            rec_cnt_q   <= 32'h0;
        end else begin
            if (lose & ~rec_end & cont_eff) begin
                drop_q <= 1'b1;
            end else if (acc_w & rec_end) begin
                drop_q <= 1'b0;
            end
            if (lose & (rec_end | ~cont_eff)) begin
                term_pend_q <= 1'b1;
            end else if (term_wr) begin
                term_pend_q <= 1'b0;
            end
            if (lose) begin
                rec_lost_q <= 1'b1;
            end else if (term_wr | (dat_wr & rec_end)) begin
                rec_lost_q <= 1'b0;
            end
            if (start_p | acc_w) begin
                rec_cnt_q <= (start_p | rec_end) ? 32'h0 : rec_cnt_q + 32'd1;
            end
        end
    end

    // Read side into the one-word output register
    toe_entry_s head;
    logic adv, fire, rd_close, ld_dat;
    assign head     = mem[rd_ptr_q];
    assign link_valid = lv_q & (credits_q != 8'h0);
    assign fire     = link_valid & link_ready;
    assign adv      = ~lv_q | fire;
    assign ld_dat   = (rd_st_q == RD_DATA) & ~empty & ~head.nodata & adv;
    assign pop      = (rd_st_q == RD_DATA) & ~empty & (head.nodata | adv);
    assign rd_close = pop & head.last;
    assign link_data = ld_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_st_q  <= RD_DATA;
            rd_len_q <= 24'h0;
            hdr_q    <= 32'h0;
            disc_q   <= 1'b0;
        end else begin
            disc_q <= rd_close & head.lost & ~cfg_q.part;
            unique case (rd_st_q)
                RD_DATA: begin
                    if (ld_dat) begin
                        rd_len_q <= rd_len_q + 24'd1;
                    end
                    if (rd_close) begin
                        rd_len_q <= 24'h0;
                        hdr_q <= 32'h0;
                        hdr_q[HDR_LEN_LO +: 24] <= rd_len_q + 24'(ld_dat);
                        hdr_q[HDR_LOST_BIT]     <= head.lost;
                        if (cfg_q.hdr) begin
                            rd_st_q <= RD_HDR;
                        end
                    end
                end
                RD_HDR: begin
                    if (adv) begin
                        rd_st_q <= RD_DATA;
                    end
                end
            endcase
        end
    end
    assign discard_evt = disc_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lv_q <= 1'b0;
            ll_q <= 1'b0;
            ld_q <= 32'h0;
        end else if (adv) begin
            lv_q <= ld_dat | (rd_st_q == RD_HDR);
            ll_q <= (ld_dat & head.last & ~cfg_q.hdr) | (rd_st_q == RD_HDR);
            ld_q <= (rd_st_q == RD_HDR) ? hdr_q : head.data;
        end
    end

    // Eject sources
    logic ej_ev, tmo_hit, ej_do, hand;
    assign tmo_hit = (tmo_q != 32'h0) & (idle_q == tmo_q);
    assign ej_ev   = flush_p
                   | tmo_hit
                   | ((cfg_q.src == SRC_REC_END) & fire & ll_q)
                   | ((cfg_q.src == SRC_PATTERN) & pat_gen_in);
    // Eject not held off by a busy link; word in flight joins buffer
    assign ej_do   = ej_pend_q;
    assign hand    = (fire & (fill_q == FW'(TB_WORDS - 1)))
                   | (ej_do & ((fill_q != '0) | fire));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_q <= 32'h0;
        end else if (dat_wr | (acc_w & (rec_cnt_q == 32'h0))) begin
            idle_q <= 32'h0;
        end else if (idle_q != tmo_q) begin
            idle_q <= idle_q + 32'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ej_pend_q <= 1'b0;
        end else if (ej_ev) begin
            ej_pend_q <= 1'b1;
        end else if (ej_do) begin
            ej_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_q    <= '0;
            credits_q <= 8'(CREDITS);
            hand_q    <= 1'b0;
            words_q   <= 32'h0;
        end else begin
            hand_q <= hand;
            if (hand) begin
                fill_q  <= '0;
                words_q <= 32'(fill_q) + 32'(fire);
            end else if (fire) begin
                fill_q <= fill_q + FW'(1);
            end
            credits_q <= credits_q - 8'(hand) + 8'(buf_release);
        end
    end
    assign tb_handover = hand_q;
    assign tb_words    = words_q;

    halt_ovf_a: assert property (@(posedge pclk) disable iff (!presetn)
        ovf_ev & ~cont_eff & ~start_p |=> ~run_q)
        else $error("acquisition kept running after overflow");
    flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        ovf_q & ~start_p |=> ovf_q)
        else $error("overflow flag dropped without restart");
    ovf_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc_w & full |=> ovf_q)
        else $error("dropped word not flagged as overflow");
    room_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc_w & ~full & ~block_q & ~drop_q & ~term_pend_q & ~pop
        |=> level_q == $past(level_q) + 1'b1)
        else $error("word dropped while memory had room");
    block_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        block_q & (32'(level_q) > thresh) & ~start_p |=> block_q)
        else $error("refill unblocked before margin drained");
    no_credit_a: assert property (@(posedge pclk) disable iff (!presetn)
        credits_q == 8'h0 |-> ~link_valid)
        else $error("data sent with no host buffer");
    cont_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
        rlen_q == UNBOUNDED_LEN |-> ~cont_eff)
        else $error("continue mode active with unbounded length");
    empty_eject_a: assert property (@(posedge pclk) disable iff (!presetn)
        tb_handover |-> tb_words != 32'h0)
        else $error("empty buffer handed over");
    hdr_next_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_close & cfg_q.hdr |=> rd_st_q == RD_HDR)
        else $error("no header after record");
    flush_go_a: assert property (@(posedge pclk) disable iff (!presetn)
        flush_p & (fill_q != '0) & ~fire |=> ##[0:8] tb_handover)
        else $error("software flush not honoured");
endmodule // toe_core

// file: bench/toe_host_model.sv
// Purpose: host side model that takes link words and frees buffers
// Assumes: one release owed for every buffer handed over
// Notes:   stall drops ready, hold withholds releases
`timescale 1ns/1ps
module toe_host_model (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Test controls
    input  wire logic stall,
    input  wire logic hold,
    // Link side
    input  wire logic tb_handover,
    output logic      link_ready,
    output logic      buf_release
);
    logic [7:0] owed_q;
    logic       rel;

    // One-cycle pulses, never two in a row
    assign rel = !hold && !buf_release && owed_q != 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            owed_q      <= 8'h00;
            buf_release <= 1'b0;
            link_ready  <= 1'b0;
        end else begin
            // Any record length is taken
            link_ready  <= !stall;
            buf_release <= rel;
            owed_q      <= owed_q + {7'h00, tb_handover} - {7'h00, rel};
        end
    end
endmodule // toe_host_model

// file: bench/transfer_overflow_eject_bench.sv
// Purpose: self-checking bench of the overflow and eject block
// Assumes: small memory (16) and buffers (4 words)
// Notes:   register cases in a table, flows written out after it
`timescale 1ns/1ps
module transfer_overflow_eject_bench;
    import toe_pkg::*;

    typedef struct packed {
        logic [7:0]  a;
        logic        w;
        logic [31:0] d;
        logic [31:0] e;
    } toe_row_s;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, acq_data, link_data, tb_words, r, last_words;
    logic        acq_valid, acq_last, pat_gen_in, link_valid, link_ready;
    logic        tb_handover, buf_release, discard_evt, stall, hold, e, lost_seen;
    logic [31:0] rx_q [$];
    toe_row_s    rows [12];
    int          failures, samples_checked, hand_cnt, disc_cnt, n0;

    toe_core #(.DEPTH(16), .TB_WORDS(4), .CREDITS(4)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .acq_valid(acq_valid),
        .acq_data(acq_data), .acq_last(acq_last), .pat_gen_in(pat_gen_in),
        .link_valid(link_valid), .link_data(link_data), .link_ready(link_ready),
        .tb_handover(tb_handover), .tb_words(tb_words),
        .buf_release(buf_release), .discard_evt(discard_evt));

    toe_host_model host (
        .pclk(pclk), .presetn(presetn), .stall(stall), .hold(hold),
        .tb_handover(tb_handover), .link_ready(link_ready),
        .buf_release(buf_release));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (link_valid === 1'b1 && link_ready === 1'b1) begin
            rx_q.push_back(link_data);
            if (link_data[31:28] === 4'h0 && link_data[0] === 1'b1) lost_seen = 1'b1;
        end
        if (tb_handover === 1'b1) begin
            hand_cnt++;
            last_words = tb_words;
        end
        if (discard_evt === 1'b1) disc_cnt++;
    end

    task automatic report_and_stop();
        $display("checked %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic send(input int n, input logic lst, input logic [31:0] base);
        for (int i = 0; i < n; i++) begin
            acq_valid <= 1'b1;
            acq_data  <= base + i;
            acq_last  <= lst && (i == n - 1);
            @(posedge pclk);
        end
        acq_valid <= 1'b0;
        acq_last  <= 1'b0;
        @(posedge pclk);
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        report_and_stop();
    end

    initial begin
        {presetn, psel, penable, pwrite, acq_valid, acq_last, pat_gen_in} = 7'h00;
        {stall, hold, lost_seen} = 3'h0;
        paddr    = 8'h00;
        pwdata   = 32'h0;
        acq_data = 32'h0;
        rows = '{'{OFF_HYST, 1'b0, 32'h0, 32'h4}, '{OFF_RLEN, 1'b0, 32'h0, 32'h100},
                 '{OFF_TMO, 1'b0, 32'h0, 32'h0}, '{OFF_STAT, 1'b0, 32'h0, 32'h0},
                 '{OFF_HYST, 1'b1, 32'h7, 32'h6}, '{OFF_HYST, 1'b1, 32'hc8, 32'h64},
                 '{OFF_RLEN, 1'b1, 32'hffff_ffff, 32'hffff_ffff},
                 '{OFF_CFG, 1'b1, 32'h1, 32'h0}, '{OFF_RLEN, 1'b1, 32'h4, 32'h4},
                 '{OFF_CFG, 1'b1, 32'h1, 32'h1}, '{8'h20, 1'b1, 32'h5, 32'h0},
                 '{OFF_CFG, 1'b1, 32'h0, 32'h0}};
        tick(2);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 12; i++) begin
            if (rows[i].w) apb(rows[i].a, 1'b1, rows[i].d);
            apb(rows[i].a, 1'b0, 32'h0);
            chk(r, rows[i].e);
            chk({31'h0, e}, {31'h0, rows[i].a == 8'h20});
        end
        $display("test registers complete");
        apb(OFF_CTRL, 1'b1, 32'h1);
        send(3, 1'b0, 32'hd000_0100);
        tick(10);
        chk(hand_cnt, 0);
        apb(OFF_CTRL, 1'b1, 32'h4);
        tick(10);
        chk(hand_cnt, 1);
        chk(last_words, 3);
        apb(OFF_CTRL, 1'b1, 32'h4);
        tick(10);
        chk(hand_cnt, 1);
        $display("test flush complete");
        apb(OFF_TMO, 1'b1, 32'h14);
        for (int i = 0; i < 3; i++) begin
            send(1, 1'b1, 32'hd000_0200 + i);
            tick(11);
        end
        chk(hand_cnt, 1);
        tick(40);
        chk(hand_cnt, 2);
        chk(last_words, 3);
        apb(OFF_TMO, 1'b1, 32'h0);
        $display("test timeout complete");
        apb(OFF_CFG, 1'b1, 32'h12);
        send(2, 1'b1, 32'hd000_0300);
        tick(20);
        chk(hand_cnt, 3);
        chk(last_words, 3);
        chk(rx_q[$], 32'h0000_0200);
        $display("test record end complete");
        apb(OFF_CFG, 1'b1, 32'h20);
        send(1, 1'b0, 32'hd000_0400);
        tick(10);
        chk(hand_cnt, 3);
        pat_gen_in <= 1'b1;
        tick(2);
        pat_gen_in <= 1'b0;
        tick(10);
        chk(hand_cnt, 4);
        chk(last_words, 1);
        $display("test pattern complete");
        apb(OFF_CFG, 1'b1, 32'h0);
        n0 = rx_q.size();
        stall <= 1'b1;
        send(24, 1'b0, 32'hd000_0500);
        apb(OFF_STAT, 1'b0, 32'h0);
        chk(r & 32'h3, 32'h2);
        stall <= 1'b0;
        tick(200);
        chk(rx_q[n0], 32'hd000_0500);
        chk({31'h0, rx_q.size() - n0 >= 16}, 32'h1);
        apb(OFF_CTRL, 1'b1, 32'h1);
        apb(OFF_STAT, 1'b0, 32'h0);
        chk(r & 32'h3, 32'h1);
        $display("test halt complete");
        n0 = disc_cnt;
        hold <= 1'b1;
        apb(OFF_CFG, 1'b1, 32'h3);
        send(40, 1'b0, 32'hd000_0600);
        apb(OFF_STAT, 1'b0, 32'h0);
        chk(r & 32'h7, 32'h7);
        hold <= 1'b0;
        tick(400);
        chk({31'h0, lost_seen}, 32'h1);
        chk({31'h0, disc_cnt != n0}, 32'h1);
        $display("test continue complete");
        presetn <= 1'b0;
        tick(2);
        chk({29'h0, link_valid, tb_handover, discard_evt}, 32'h0);
        chk(tb_words, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({29'h0, link_valid, tb_handover, discard_evt}, 32'h0);
        apb(OFF_STAT, 1'b0, 32'h0);
        chk(r, 32'h0);
        apb(OFF_HYST, 1'b0, 32'h0);
        chk(r, 32'h4);
        $display("test reset complete");
        report_and_stop();
    end
endmodule // transfer_overflow_eject_bench
